//--- rtl/pcc_engine.sv
// Packet check-code engine: receive checker and transmit appender.
// Assumes serial bits arrive one per enable from same-clock shift logic.
// What this block does
// R1 - 15-bit CRC over every data bit, link order
// R2 - Seed register with only bit 4 set
// R3 - Polynomial x15+x14+x10+x8+x7+x4+x3+1, mask 0x4599
// R4 - Feedback is input XOR bit 14; taps
// R5 - Bit 0 gets feedback; others shift left
// R6 - Code valid only after last bit in
// R7 - Sent word is register shifted, zero LSB
// R8 - Check received groups; accept only on match
// R9 - Append own code right after sent data
// R10 - High byte bits 14..7; low byte 6..0,0
// R11 - Host computes and checks codes too
// R12 - Host may use byte table method
// R13 - Fresh code after every six read bytes
// R14 - Clear reseeds, enable steps, mismatch flags error
`timescale 1ns/1ns
module pcc_engine
  import pcc_pkg::*;
#(
  parameter int GROUP_LEN = GROUP_BYTES
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Receive bit stream
  input  wire logic        rx_clear,
  input  wire logic        rx_bit_en,
  input  wire logic        rx_bit,
  input  wire logic        rx_check,
  // Receive verdict
  output logic             rx_done,
  output logic             rx_ok,
  output logic             rx_error,
  output logic [14:0]      rx_crc,
  // Transmit byte source
  input  wire logic        tx_start,
  input  wire logic        tx_valid,
  output logic             tx_ready,
  input  wire logic [7:0]  tx_data,
  // Transmit serial out
  input  wire logic        tx_bit_en,
  output logic             tx_bit,
  output logic             tx_bit_valid,
  output logic             tx_check_phase
);
  // Receive side
  logic [14:0] rx_crc_reg;
  logic [15:0] rx_sh_reg;
  logic        rx_done_reg;
  logic        rx_ok_reg;
  logic        rx_err_reg;
  logic [14:0] rx_hold_reg;
  wire  [14:0] rx_crc_next = pcc_step(rx_crc_reg, rx_bit); // R1 R3 R4 R5
  // Last 16 bits are the trailing check bytes; code must be taken before them
  logic [14:0] rx_lag_reg [16];
  wire  [14:0] rx_data_crc = rx_lag_reg[15]; // R6
  wire         rx_match    = ({rx_data_crc, 1'b0} == rx_sh_reg); // R7 R10

  always_ff @(posedge clock) begin
    if (!rst_n || rx_clear) begin
      rx_crc_reg <= CRC_SEED; // R2 R14
      rx_sh_reg  <= '0;
    end else if (rx_bit_en) begin
      rx_crc_reg <= rx_crc_next; // R14
      rx_sh_reg  <= {rx_sh_reg[14:0], rx_bit};
    end
  end

  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_lag
      // Head stage split off so no stage ever names an index below zero
      if (g == 0) begin : g_head
        always_ff @(posedge clock) begin
          if (!rst_n || rx_clear) begin
            rx_lag_reg[g] <= CRC_SEED;
          end else if (rx_bit_en) begin
            rx_lag_reg[g] <= rx_crc_reg;
          end
        end
      end else begin : g_tail
        always_ff @(posedge clock) begin
          if (!rst_n || rx_clear) begin
            rx_lag_reg[g] <= CRC_SEED;
          end else if (rx_bit_en) begin
            rx_lag_reg[g] <= rx_lag_reg[g-1];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rx_done_reg <= 1'b0;
      rx_ok_reg   <= 1'b0;
      rx_err_reg  <= 1'b0;
      rx_hold_reg <= '0;
    end else begin
      rx_done_reg <= rx_check;
      if (rx_check) begin
        rx_ok_reg   <= rx_match; // R8
        rx_err_reg  <= !rx_match; // R14
        rx_hold_reg <= rx_data_crc;
      end else if (rx_clear) begin
        rx_ok_reg  <= 1'b0;
        rx_err_reg <= 1'b0;
      end
    end
  end

  assign rx_done  = rx_done_reg;
  assign rx_ok    = rx_ok_reg;
  assign rx_error = rx_err_reg;
  assign rx_crc   = rx_hold_reg;

  // Transmit side; FIFO decouples byte producer from bit pacing
  logic        f_valid;
  logic        f_ready;
  logic [7:0]  f_data;
  logic        in_rdy;
  // Ready is registered, so it must already count the push it admits
  localparam int OCC_W = $clog2(FIFO_DEPTH) + 1;
  logic             rdy_reg;
  logic [OCC_W-1:0] occ_reg;
  wire              push_acc = tx_valid && rdy_reg && in_rdy;

  pcc_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_valid  (push_acc),
    .in_ready  (in_rdy),
    .in_data   (tx_data),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );

  pcc_tx_state_t st_reg;
  pcc_tx_state_t st_next;
  logic [14:0]   tx_crc_reg;
  logic [7:0]    tx_sh_reg;
  logic [2:0]    bit_reg;
  logic [2:0]    byte_reg;
  logic          busy_reg;
  logic          out_bit_reg;
  logic          out_vld_reg;
  logic          chk_reg;

  wire byte_end   = tx_bit_en && busy_reg && (bit_reg == BIT_LAST);
  wire group_full = (byte_reg == 3'(GROUP_LEN - 1));
  wire load_byte  = (st_reg == PCC_DATA) && !busy_reg && f_valid;
  wire [15:0] chk_word = {tx_crc_reg, 1'b0}; // R7
  // Check bytes enter the shifter once the data bytes are done
  wire load_chk0  = (st_reg == PCC_CHK0) && !busy_reg;
  wire load_chk1  = (st_reg == PCC_CHK1) && !busy_reg;
  assign f_ready  = load_byte;
  // Fill level after this edge; load_byte is exactly the FIFO pop
  wire [OCC_W-1:0] occ_next = occ_reg + OCC_W'(push_acc) - OCC_W'(load_byte);

  always_comb begin
    st_next = st_reg;
    case (st_reg)
      PCC_IDLE: begin
        if (tx_start) begin
          st_next = PCC_DATA;
        end
      end
      PCC_DATA: begin
        if (byte_end && group_full) begin
          st_next = PCC_CHK0; // R9 R13
        end
      end
      PCC_CHK0: begin
        if (byte_end) begin
          st_next = PCC_CHK1;
        end
      end
      PCC_CHK1: begin
        if (byte_end) begin
          st_next = f_valid ? PCC_DATA : PCC_IDLE; // R13
        end
      end
      default: st_next = PCC_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_reg <= PCC_IDLE;
      tx_crc_reg <= CRC_SEED;
      tx_sh_reg <= '0;
      bit_reg <= '0;
      byte_reg <= '0;
      busy_reg <= 1'b0;
      out_bit_reg <= 1'b0;
      out_vld_reg <= 1'b0;
      chk_reg <= 1'b0;
      rdy_reg <= 1'b0;
      occ_reg <= '0;
    end else begin
      st_reg <= st_next;
      rdy_reg <= (occ_next != OCC_W'(FIFO_DEPTH));
      occ_reg <= occ_next;
      out_vld_reg <= busy_reg;
      chk_reg <= (st_reg == PCC_CHK0) || (st_reg == PCC_CHK1);
      if (tx_start && st_reg == PCC_IDLE) begin
        tx_crc_reg <= CRC_SEED; // R2
        byte_reg <= '0;
      end
      if (load_byte) begin
        tx_sh_reg <= f_data;
        busy_reg <= 1'b1;
        bit_reg <= '0;
      end else if (load_chk0) begin
        tx_sh_reg <= chk_word[15:8]; // R10
        busy_reg <= 1'b1;
        bit_reg <= '0;
      end else if (load_chk1) begin
        tx_sh_reg <= chk_word[7:0]; // R10
        busy_reg <= 1'b1;
        bit_reg <= '0;
      end else if (tx_bit_en && busy_reg) begin
        out_bit_reg <= tx_sh_reg[7];
        tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
        bit_reg <= bit_reg + 3'h1;
        if (st_reg == PCC_DATA) begin
          tx_crc_reg <= pcc_step(tx_crc_reg, tx_sh_reg[7]); // R1 R4 R5
        end
        if (byte_end) begin
          busy_reg <= 1'b0;
          if (st_reg == PCC_DATA) begin
            byte_reg <= group_full ? 3'h0 : byte_reg + 3'h1;
          end
          if (st_reg == PCC_CHK1) begin
            tx_crc_reg <= CRC_SEED; // R13
          end
        end
      end
    end
  end

  assign tx_ready       = rdy_reg;
  assign tx_bit         = out_bit_reg;
  assign tx_bit_valid   = out_vld_reg;
  assign tx_check_phase = chk_reg;
endmodule

//--- rtl/pcc_fifo.sv
// Byte FIFO with valid/ready on both sides.
// Assumes a single clock and synchronous active-low reset.
`timescale 1ns/1ns
module pcc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    rd_reg;
  logic [AW:0]      cnt_reg;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem[rd_reg];

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_reg] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= rd_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

//--- rtl/pcc_pkg.sv
// Package for the packet check-code engine: seed, polynomial, group sizes.
// Assumes one clock domain; imported by pcc_engine, not by pcc_fifo.
package pcc_pkg;
  localparam int          CRC_W        = 15;
  localparam logic [14:0] CRC_SEED     = 15'h0010;
  localparam logic [14:0] CRC_POLY     = 15'h4599;
  localparam int          GROUP_BYTES  = 6;
  localparam int          CHECK_BYTES  = 2;
  localparam int          FIFO_DEPTH   = 16;
  localparam int          BYTE_W       = 8;
  localparam logic [2:0]  BIT_LAST     = 3'h7;

  typedef enum logic [1:0] {
    PCC_IDLE = 2'b00,
    PCC_DATA = 2'b01,
    PCC_CHK0 = 2'b10,
    PCC_CHK1 = 2'b11
  } pcc_tx_state_t;

  // Applies one serial bit to the register.
  function automatic logic [14:0] pcc_step(input logic [14:0] crc, input logic din);
    logic       fb;
    logic [14:0] n;
    fb = din ^ crc[14];
    n = {crc[13:0], fb};
    n = n ^ ({15{fb}} & (CRC_POLY & 15'h7ffe));
    return n;
  endfunction
endpackage

//--- verif/pcc_engine_props.sv
// Port checker for the check-code engine.
// Assumes it is bound onto pcc_engine.
`timescale 1ns/1ns
module pcc_engine_props (
  // Clock, reset, receive side
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        rx_clear,
  input wire logic        rx_bit_en,
  input wire logic        rx_check,
  input wire logic        rx_done,
  input wire logic        rx_ok,
  input wire logic        rx_error,
  input wire logic [14:0] rx_crc,
  // Transmit side
  input wire logic        tx_bit_en,
  input wire logic        tx_bit,
  input wire logic        tx_check_phase
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Two check bytes at one bit per enable last sixteen cycles at least
  sequence chk_half;
    tx_check_phase [*8];
  endsequence
  done_after_chk_a: assert property (rx_check |=> rx_done)
    else $error("no done");
  done_cause_a: assert property (rx_done |-> $past(rx_check))
    else $error("stray done");
  one_verdict_a: assert property (rx_done |-> rx_ok != rx_error)
    else $error("bad verdict");
  clear_flags_a: assert property (rx_clear && !rx_check |=> !rx_ok && !rx_error)
    else $error("flags kept");
  flags_hold_a: assert property (!rx_check && !rx_clear |=> $stable({rx_ok, rx_error}))
    else $error("flags moved");
  crc_hold_a: assert property (!rx_bit_en && !rx_clear && !rx_check |=> $stable(rx_crc))
    else $error("code moved");
  tx_hold_a: assert property (!tx_bit_en && !$past(tx_bit_en) |=> $stable(tx_bit))
    else $error("bit moved");
  chk_len_a: assert property ($rose(tx_check_phase) |-> chk_half ##1 chk_half)
    else $error("short check");
endmodule
bind pcc_engine pcc_engine_props u_props (.*);

//--- verif/pcc_host_model.sv
// Host model: pulls serial bits, checks data and code of each group.
// Assumes six-byte groups, each followed by two check bytes.
`timescale 1ns/1ns
module pcc_host_model (
  // Clock and control
  input wire logic clock,
  input wire logic go,
  // Serial stream
  input wire logic tx_bit,
  input wire logic tx_bit_valid,
  input wire logic tx_check_phase,
  output logic     tx_bit_en,
  // Results
  output int       groups,
  output int       bad
);
  logic [63:0] sh;
  logic [14:0] c;
  int          n;
  int          nb;
  logic [15:0] tab [256];
  logic [15:0] rem;
  // Bitwise and byte-table references must agree on every group
  function automatic logic [14:0] step(logic [14:0] r, logic d);
    logic f;
    f = d ^ r[14];
    return {r[13:0], f} ^ ({15{f}} & 15'h4598);
  endfunction
  initial begin
    {tx_bit_en, groups, bad, n, nb} = '0;
    for (int i = 0; i < 256; i++) begin
      rem = 16'(i << 7);
      repeat (8) rem = rem[14] ? ((rem << 1) ^ 16'h4599) : (rem << 1);
      tab[i] = rem;
    end
    forever begin
      @(posedge clock);
      if (go) begin
        if (n[2]) @(posedge clock);
        tx_bit_en <= 1'b1;
        @(posedge clock);
        tx_bit_en <= 1'b0;
        @(negedge clock);
        if (tx_bit_valid || tx_check_phase) begin
          if (tx_check_phase !== (n >= 48)) bad++;
          sh = {sh[62:0], tx_bit};
          n++;
        end
        if (n == 64) begin
          c = 15'h0010;
          for (int i = 63; i >= 16; i--) c = step(c, sh[i]);
          if (sh[15:0] !== {c, 1'b0}) bad++;
          rem = 16'h0010;
          for (int j = 0; j < 6; j++) rem = (rem << 8) ^ tab[8'(rem[14:7] ^ sh[63-8*j -: 8])];
          if (16'(rem << 1) !== {c, 1'b0}) bad++;
          for (int j = 0; j < 6; j++) begin
            if (sh[63-8*j -: 8] !== 8'(8'h30 + nb)) bad++;
            nb++;
          end
          groups++;
          n = 0;
        end
      end
    end
  end
endmodule

//--- verif/tb_packet_crc15_checker.sv
// Self-checking bench for the check-code engine and a host model.
// Assumes engine, FIFO, checker and host model are compiled first.
`timescale 1ns/1ns
module tb_packet_crc15_checker;
  logic        clock, rst_n, rx_clear, rx_bit_en, rx_bit, rx_check, tx_start, tx_valid, go;
  logic        rx_done, rx_ok, rx_error, tx_ready, tx_bit_en, tx_bit, tx_bit_valid;
  logic        tx_check_phase, full_seen;
  logic [14:0] rx_crc;
  logic [7:0]  tx_data;
  int          groups, bad, n_errors, checked, cyc;
  pcc_engine DUT (.*);
  pcc_host_model host (.*);
  task automatic cmp_word(string nm, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic tally_and_finish();
    if (n_errors == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic rx_case(logic [31:0] v, int nb, logic ok, logic [14:0] crc);
    @(posedge clock) rx_clear <= 1'b1;
    for (int i = nb - 1; i >= 0; i--) begin
      @(posedge clock);
      {rx_clear, rx_bit_en, rx_bit} <= {2'b01, v[i]};
    end
    @(posedge clock);
    {rx_bit_en, rx_check} <= 2'b01;
    @(posedge clock) rx_check <= 1'b0;
    @(negedge clock);
    cmp_word("rx_done", 1, rx_done);
    cmp_word("rx_ok", ok, rx_ok);
    cmp_word("rx_error", !ok, rx_error);
    cmp_word("rx_crc", crc, rx_crc);
  endtask
  task automatic tx_case();
    @(posedge clock) tx_start <= 1'b1;
    @(posedge clock) tx_start <= 1'b0;
    fork
      for (int i = 0; i < 18; i++) begin
        logic r;
        {tx_valid, tx_data} <= {1'b1, 8'(8'h30 + i)};
        do begin
          @(negedge clock) r = tx_ready;
          full_seen |= !r;
          @(posedge clock);
        end while (!r);
      end
      begin
        repeat (60) @(posedge clock);
        go <= 1'b1;
      end
    join
    tx_valid <= 1'b0;
    for (int k = 0; k < 4000 && groups < 3; k++) @(posedge clock);
    cmp_word("tx_ready low", 1, full_seen);
    cmp_word("groups", 3, groups);
    cmp_word("host bad", 0, bad);
  endtask
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // Cycle ceiling well above the roughly 650 cycles the tests need
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  initial begin
    {rst_n, rx_clear, rx_bit_en, rx_bit, rx_check, tx_start, tx_valid, go} = '0;
    {tx_data, n_errors, checked, cyc, full_seen} = '0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    rx_case(32'h00013d6e, 32, 1'b1, 15'h1eb7);
    rx_case(32'h00013d6f, 32, 1'b0, 15'h1eb7);
    rx_case(32'h00000020, 16, 1'b1, 15'h0010);
    tx_case();
    tally_and_finish();
  end
endmodule
